// ===== common/guard_if.sv
// Connection between the controller and one bridge overcurrent guard
`timescale 1ns/1ps
interface guard_if;
  logic oc_hs;
  logic oc_ls;
  logic clr;
  logic tripped;
  logic trip_evt;
  modport ctl   (output oc_hs, oc_ls, clr, input tripped, trip_evt);
  modport guard (input oc_hs, oc_ls, clr, output tripped, trip_evt);
endinterface

// ===== common/motor_ctl_pkg.sv
// Shared constants and types for the motor driver control logic
package motor_ctl_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int WAKE_TIME_US  = 1000;
  localparam int RETRY_TIME_US = 1200;
  localparam int OC_FILTER_NS  = 3000;
  // Longest times round down, least times round up
  localparam int WAKE_CYC      = WAKE_TIME_US * CLK_PER_US;
  localparam int RETRY_CYC     = RETRY_TIME_US * CLK_PER_US;
  localparam int OC_FILTER_CYC = (OC_FILTER_NS * CLK_PER_US + 999) / 1000;
  localparam int CNT_W         = 17;
  // ---------------------------------------------------------------
  // Indexer: 128 positions per electrical turn
  // ---------------------------------------------------------------
  localparam int         IDX_W    = 7;
  localparam logic [6:0] HOME_IDX = 7'h10;
  localparam logic [6:0] A_POS_LO = 7'h20;
  localparam logic [6:0] A_POS_HI = 7'h60;
  localparam logic [6:0] B_POS_HI = 7'h40;
  localparam logic [6:0] INC_1    = 7'h20;
  localparam logic [6:0] INC_2    = 7'h10;
  localparam logic [6:0] INC_4    = 7'h08;
  localparam logic [6:0] INC_8    = 7'h04;
  localparam logic [6:0] INC_16   = 7'h02;
  localparam logic [6:0] INC_32   = 7'h01;
  typedef enum logic [1:0] {
    DEC_SLOW  = 2'h0,
    DEC_FAST  = 2'h1,
    DEC_MIXED = 2'h2,
    DEC_OFF   = 2'h3
  } decay_t;
  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_WAKE = 3'h2,
    ST_RUN  = 3'h4
  } state_t;
  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam int         DATA_W     = 8;
  localparam int         EV_W       = 5;
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_MASK   = 4'h4;
  localparam logic [3:0] ADR_STATE  = 4'h8;
  localparam logic [3:0] ADR_INDEX  = 4'hc;
endpackage

// ===== hdl/bridge_guard.sv
// Overcurrent filter and retry timer for one bridge
`timescale 1ns/1ps
module bridge_guard #(
  parameter int FILT_CYC  = motor_ctl_pkg::OC_FILTER_CYC,
  parameter int RETRY_CYC = motor_ctl_pkg::RETRY_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  guard_if.guard    g
);
  localparam int W = motor_ctl_pkg::CNT_W;
  logic         fault;
  logic         trip;
  logic         tripped_r;
  logic [W-1:0] filt_r;
  logic [W-1:0] retry_r;

  assign fault = g.oc_hs | g.oc_ls;
  // Trips only after the fault has outlasted the filter window
  assign trip  = fault && !tripped_r && (filt_r == W'(FILT_CYC));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || g.clr || !fault || tripped_r) begin
      filt_r <= '0;
    end else if (filt_r != W'(FILT_CYC)) begin
      filt_r <= filt_r + W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || g.clr) begin
      tripped_r <= 1'b0;
    end else if (trip) begin
      tripped_r <= 1'b1;
    end else if (tripped_r && retry_r == '0) begin
      tripped_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !tripped_r) begin
      retry_r <= W'(RETRY_CYC - 1);
    end else if (retry_r != '0) begin
      retry_r <= retry_r - W'(1);
    end
  end

  assign g.tripped  = tripped_r;
  assign g.trip_evt = trip;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_OC_TRIP: assert property (@(posedge i_clk_sys) disable iff (i_rst || g.clr)
    fault && !tripped_r && filt_r == W'(FILT_CYC) |=> tripped_r)
    else $error("overcurrent not tripped after filter time");
  AST_OC_RETRY: assert property (@(posedge i_clk_sys) disable iff (i_rst || g.clr)
    $rose(tripped_r) |-> tripped_r && retry_r == W'(RETRY_CYC - 1))
    else $error("retry period not loaded on trip");
  AST_OC_RELEASE: assert property (@(posedge i_clk_sys) disable iff (i_rst || g.clr)
    $fell(tripped_r) |-> $past(retry_r) == '0)
    else $error("bridge released before retry period ended");
  COV_OC_CYCLE: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(tripped_r));
endmodule

// ===== hdl/stepper_sleep_fault_control.sv
// Sleep, fault, protection and indexer control of a dual bridge motor driver
// Notes on behaviour
// - Sleep request low disables bridges, pump, clocks; resets logic, indexer home.
// - In sleep every other input is ignored until sleep request returns high; here the register port and overheat/low supply status events still work.
// - Leaving sleep holds error flag low until supplies settle, up to 1 ms.
// - Current limit longer than filter time disables that bridge, error flag low.
// - Bridge and flag re-enabled after about 1.2 ms retry; repeats if fault stays.
// - Overcurrent shutdown affects only its own bridge; other keeps running.
// - High-side and low-side overcurrent detected separately, no sense resistor needed.
// - Overheat disables bridges and pulls flag low; resumes when safe.
// - Low supply disables everything and resets logic; resumes when supply recovers.
// - Flag low during low supply, power-up and sleep exit until supplies settle.
// - Each rising step edge advances the indexer by one step.
// - Direction input reverses the order of the step sequence.
// - Microstep selects choose full, half, down to 1/32 step.
// - Phase mode, upper select low: gate low gives slow decay for PWM.
// - Phase mode, upper select high: gate low puts bridge in zero current.
// - Decay select low slow, high fast, floating mixed.
// - Phase mode: phase input sets coil current direction per coil.
`timescale 1ns/1ps
module stepper_sleep_fault_control #(
  parameter int WAKE_CYC  = motor_ctl_pkg::WAKE_CYC,
  parameter int RETRY_CYC = motor_ctl_pkg::RETRY_CYC
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  input  wire logic                          i_low_power_request_n,
  input  wire logic                          i_low_supply_guard,
  input  wire logic                          i_overheat_guard,
  input  wire logic                          i_indexer_mode,
  input  wire logic                          i_step,
  input  wire logic                          i_dir,
  input  wire logic                          i_microstep_sel_lo,
  input  wire logic                          i_microstep_sel_lo_hiz,
  input  wire logic                          i_microstep_sel_hi,
  input  wire logic [1:0]                    i_phase,
  input  wire logic [1:0]                    i_bridge_drive_gate,
  input  wire logic [1:0]                    i_decay_select,
  input  wire logic [1:0]                    i_decay_select_hiz,
  input  wire logic [1:0]                    i_oc_high_side,
  input  wire logic [1:0]                    i_oc_low_side,
  input  wire logic [3:0]                    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [7:0]                    o_rdata,
  output logic                               o_irq,
  output logic                               o_error_flag_n_o,
  output logic                               o_error_flag_n_oe,
  output logic                               o_regulator_en,
  output logic                               o_charge_pump_en,
  output logic                               o_clocks_run,
  output logic      [1:0]                    o_bridge_en,
  output logic      [1:0]                    o_drive_on,
  output logic      [1:0]                    o_coil_dir,
  output motor_ctl_pkg::decay_t [1:0]        o_decay_mode,
  output logic      [6:0]                    o_step_index
);
  localparam int W     = motor_ctl_pkg::CNT_W;
  localparam int IN_W  = 21;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [IN_W-1:0] sync1_r;
  logic [IN_W-1:0] sync2_r;
  logic            lp_n_s, low_sup_s, hot_s, idx_mode_s, step_s;
  logic            dir_s, msl_s, msl_hiz_s, msh_s;
  logic [1:0]      phase_s, gate_s, dec_s;
  logic [1:0]      dec_hiz_s, oc_hs_s, oc_ls_s;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_low_power_request_n, i_low_supply_guard, i_overheat_guard,
                  i_indexer_mode, i_step, i_dir, i_microstep_sel_lo,
                  i_microstep_sel_lo_hiz, i_microstep_sel_hi, i_phase,
                  i_bridge_drive_gate, i_decay_select, i_decay_select_hiz,
                  i_oc_high_side, i_oc_low_side};
      sync2_r <= sync1_r;
    end
  end

  assign {lp_n_s, low_sup_s, hot_s, idx_mode_s, step_s, dir_s, msl_s, msl_hiz_s,
          msh_s, phase_s, gate_s, dec_s, dec_hiz_s, oc_hs_s, oc_ls_s} = sync2_r;

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  motor_ctl_pkg::state_t state_r;
  motor_ctl_pkg::state_t state_nxt;
  logic                  down, logic_rst, run;
  logic [W-1:0]          wake_cnt_r;

  // Sleep and low supply share one path: both wipe the logic
  assign down      = !lp_n_s || low_sup_s;
  assign logic_rst = i_rst || down;
  assign run       = (state_r == motor_ctl_pkg::ST_RUN);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      motor_ctl_pkg::ST_OFF: begin
        if (!down) begin
          state_nxt = motor_ctl_pkg::ST_WAKE;
        end
      end
      motor_ctl_pkg::ST_WAKE: begin
        if (down) begin
          state_nxt = motor_ctl_pkg::ST_OFF;
        end else if (wake_cnt_r == '0) begin
          state_nxt = motor_ctl_pkg::ST_RUN;
        end
      end
      motor_ctl_pkg::ST_RUN: begin
        if (down) begin
          state_nxt = motor_ctl_pkg::ST_OFF;
        end
      end
      default: state_nxt = motor_ctl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= motor_ctl_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settling time is a fixed worst case; no analog ready signal is seen here
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_r != motor_ctl_pkg::ST_WAKE) begin
      wake_cnt_r <= W'(WAKE_CYC - 1);
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Indexer
  // ---------------------------------------------------------------
  logic                            step_prev_r, step_rise, a_dir, b_dir;
  logic [motor_ctl_pkg::IDX_W-1:0] idx_r, inc;

  // Starts high so a step pin already high at wake is not a step
  always_ff @(posedge i_clk_sys) begin
    if (logic_rst) begin
      step_prev_r <= 1'b1;
    end else begin
      step_prev_r <= step_s;
    end
  end

  assign step_rise = run && idx_mode_s && step_s && !step_prev_r;

  always_comb begin
    unique case ({msh_s, msl_hiz_s, msl_s}) inside
      3'h0:    inc = motor_ctl_pkg::INC_1;
      3'h1:    inc = motor_ctl_pkg::INC_2;
      3'h2,
      3'h3:    inc = motor_ctl_pkg::INC_4;
      3'h4:    inc = motor_ctl_pkg::INC_8;
      3'h5:    inc = motor_ctl_pkg::INC_16;
      default: inc = motor_ctl_pkg::INC_32;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (logic_rst) begin
      idx_r <= motor_ctl_pkg::HOME_IDX;
    end else if (step_rise) begin
      idx_r <= dir_s ? idx_r + inc : idx_r - inc;
    end
  end

  assign a_dir = (idx_r <= motor_ctl_pkg::A_POS_LO) || (idx_r >= motor_ctl_pkg::A_POS_HI);
  assign b_dir = (idx_r <= motor_ctl_pkg::B_POS_HI);

  // ---------------------------------------------------------------
  // Bridge control
  // ---------------------------------------------------------------
  logic [1:0]                  tripped, trip_evt, en_nxt, on_nxt, dir_nxt;
  motor_ctl_pkg::decay_t [1:0] dec_nxt;

  for (genvar b = 0; b < 2; b++) begin : gen_br
    guard_if gif ();
    motor_ctl_pkg::decay_t dec_sel;
    assign gif.oc_hs = oc_hs_s[b];
    assign gif.oc_ls = oc_ls_s[b];
    assign gif.clr   = logic_rst;
    assign tripped[b]  = gif.tripped;
    assign trip_evt[b] = gif.trip_evt;
    bridge_guard #(
      .FILT_CYC  (motor_ctl_pkg::OC_FILTER_CYC),
      .RETRY_CYC (RETRY_CYC)
    ) u_guard (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .g         (gif)
    );
    assign dec_sel = dec_hiz_s[b] ? motor_ctl_pkg::DEC_MIXED :
                     dec_s[b]     ? motor_ctl_pkg::DEC_FAST : motor_ctl_pkg::DEC_SLOW;

    always_comb begin
      // Only this bridge's own trip gates it
      en_nxt[b]  = run && !hot_s && !tripped[b];
      on_nxt[b]  = 1'b1;
      dec_nxt[b] = dec_sel;
      dir_nxt[b] = (b == 0) ? a_dir : b_dir;
      if (!idx_mode_s) begin
        dir_nxt[b] = phase_s[b];
        if (!gate_s[b]) begin
          on_nxt[b] = 1'b0;
          if (msh_s) begin
            en_nxt[b]  = 1'b0;
            dec_nxt[b] = motor_ctl_pkg::DEC_OFF;
          end else begin
            dec_nxt[b] = motor_ctl_pkg::DEC_SLOW;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (logic_rst) begin
      o_bridge_en  <= '0;
      o_drive_on   <= '0;
      o_coil_dir   <= '0;
      o_decay_mode <= '{motor_ctl_pkg::DEC_OFF, motor_ctl_pkg::DEC_OFF};
    end else begin
      o_bridge_en  <= en_nxt;
      o_drive_on   <= on_nxt;
      o_coil_dir   <= dir_nxt;
      o_decay_mode <= dec_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_step_index      <= motor_ctl_pkg::HOME_IDX;
      o_regulator_en    <= 1'b0;
      o_charge_pump_en  <= 1'b0;
      o_clocks_run      <= 1'b0;
      o_error_flag_n_oe <= 1'b1;
    end else begin
      o_step_index      <= idx_r;
      o_regulator_en    <= (state_r != motor_ctl_pkg::ST_OFF);
      o_charge_pump_en  <= (state_r != motor_ctl_pkg::ST_OFF);
      o_clocks_run      <= (state_r != motor_ctl_pkg::ST_OFF);
      o_error_flag_n_oe <= !run || hot_s || (|tripped);
    end
  end

  // Open drain: only ever pulls low
  assign o_error_flag_n_o = 1'b0;

  // ---------------------------------------------------------------
  // Event status, mask and register port
  // ---------------------------------------------------------------
  logic [motor_ctl_pkg::EV_W-1:0] status_r, mask_r, ev, clr;
  logic                           hot_prev_r, low_prev_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hot_prev_r <= 1'b0;
      low_prev_r <= 1'b0;
    end else begin
      hot_prev_r <= hot_s;
      low_prev_r <= low_sup_s;
    end
  end

  assign ev  = {(state_r == motor_ctl_pkg::ST_WAKE) && (state_nxt == motor_ctl_pkg::ST_RUN),
                low_sup_s && !low_prev_r, hot_s && !hot_prev_r, trip_evt};
  assign clr = (i_wr && i_addr == motor_ctl_pkg::ADR_STATUS) ?
               i_wdata[motor_ctl_pkg::EV_W-1:0] : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clr) | ev;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mask_r <= '0;
    end else if (i_wr && i_addr == motor_ctl_pkg::ADR_MASK) begin
      mask_r <= i_wdata[motor_ctl_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_r & mask_r);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rd) begin
      o_rdata <= '0;
    end else begin
      unique case (i_addr)
        motor_ctl_pkg::ADR_STATUS: o_rdata <= {3'h0, status_r};
        motor_ctl_pkg::ADR_MASK:   o_rdata <= {3'h0, mask_r};
        motor_ctl_pkg::ADR_STATE:  o_rdata <= {2'h0, hot_s, tripped, state_r};
        motor_ctl_pkg::ADR_INDEX:  o_rdata <= {1'h0, idx_r};
        default:                   o_rdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_SLEEP_HOLD: assert property (
    state_r == motor_ctl_pkg::ST_OFF ##1 state_r == motor_ctl_pkg::ST_OFF
    |-> o_bridge_en == 2'h0 && !o_charge_pump_en && idx_r == motor_ctl_pkg::HOME_IDX)
    else $error("sleep did not disable bridges or home the indexer");
  AST_SLEEP_IGNORE: assert property (
    !run ##1 !run |-> $stable(idx_r))
    else $error("indexer moved while not running");
  AST_WAKE_LEN: assert property (
    state_r == motor_ctl_pkg::ST_RUN && $past(state_r) != motor_ctl_pkg::ST_RUN
    |-> $past(state_r) == motor_ctl_pkg::ST_WAKE && $past(wake_cnt_r) == '0)
    else $error("run entered without full settling time");
  AST_WAKE_FLAG: assert property (
    state_r == motor_ctl_pkg::ST_WAKE |=> o_error_flag_n_oe)
    else $error("error flag released during settling");
  AST_STEP_ADV: assert property (
    step_rise && !down |=> idx_r == ($past(dir_s) ? $past(idx_r) + $past(inc)
                                                  : $past(idx_r) - $past(inc)))
    else $error("indexer did not move one step in the right sense");
  AST_HOT_OFF: assert property (
    hot_s |=> o_bridge_en == 2'h0 && o_error_flag_n_oe)
    else $error("overheat did not disable bridges and pull flag");
  AST_PE_OFF: assert property (
    run && !idx_mode_s && msh_s && !gate_s[0]
    |=> !o_bridge_en[0] && o_decay_mode[0] == motor_ctl_pkg::DEC_OFF)
    else $error("gate low with upper select high did not turn bridge off");
  AST_DECAY_SEL: assert property (
    run && idx_mode_s && dec_hiz_s[1] && !down |=> o_decay_mode[1] == motor_ctl_pkg::DEC_MIXED)
    else $error("floating decay select did not give mixed decay");

  COV_WAKE: cover property (state_r == motor_ctl_pkg::ST_WAKE ##1 run);
  COV_STEP: cover property (step_rise && msh_s && msl_hiz_s);
  COV_ONE_TRIP: cover property (tripped[0] && !tripped[1] && o_bridge_en[1]);
endmodule

// ===== verification/ctl_model.sv
// Motion controller model that issues step pulses on request
`timescale 1ns/1ps
module ctl_model #(
  parameter int HOLD = 3
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_flag_n,
  input  wire logic       i_go,
  input  wire logic [1:0] i_slow,
  output logic            o_step,
  output logic            o_busy
);
  // ----------------------------------------
  // Step pulses
  // ----------------------------------------
  // Each half of the pulse lasts HOLD to HOLD+3 cycles so the input sync never misses it
  initial begin
    o_step = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      if (i_go && i_flag_n) begin
        o_busy <= 1'b1;
        o_step <= 1'b1;
        repeat (HOLD + i_slow) @(posedge i_clk_sys);
        o_step <= 1'b0;
        repeat (HOLD + i_slow) @(posedge i_clk_sys);
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the motor driver control logic
`timescale 1ns/1ps
module tb;
  localparam int WAKE = 20;
  localparam int RETRY = 30;
  logic clk, rst, slp_n, lsup, hot, imode, raw_step, dir, lo, lohiz, hi, wr, rd, go;
  logic irq, flo, foe, reg_en, cp_en, clk_run, mstep, busy, flag_n;
  logic [1:0] ph, gate, dsel, dhiz, ochs, ocls, ben, don, cdir, slow;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [6:0] idx, e_idx, inc;
  logic [31:0] rs;
  motor_ctl_pkg::decay_t [1:0] dmode;
  logic [2:0] mt [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int n_mismatch, n_checks, k, b, c;
  assign flag_n = foe ? flo : 1'b1;
  stepper_sleep_fault_control #(.WAKE_CYC(WAKE), .RETRY_CYC(RETRY)) i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_low_power_request_n(slp_n), .i_low_supply_guard(lsup),
    .i_overheat_guard(hot), .i_indexer_mode(imode), .i_step(mstep | raw_step), .i_dir(dir),
    .i_microstep_sel_lo(lo), .i_microstep_sel_lo_hiz(lohiz), .i_microstep_sel_hi(hi),
    .i_phase(ph), .i_bridge_drive_gate(gate), .i_decay_select(dsel), .i_decay_select_hiz(dhiz),
    .i_oc_high_side(ochs), .i_oc_low_side(ocls), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_error_flag_n_o(flo), .o_error_flag_n_oe(foe),
    .o_regulator_en(reg_en), .o_charge_pump_en(cp_en), .o_clocks_run(clk_run),
    .o_bridge_en(ben), .o_drive_on(don), .o_coil_dir(cdir), .o_decay_mode(dmode),
    .o_step_index(idx));
  ctl_model i_ctl (.i_clk_sys(clk), .i_flag_n(flag_n), .i_go(go), .i_slow(slow),
    .o_step(mstep), .o_busy(busy));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [6:0] inc_of(input logic [2:0] m);
    case (m)
      3'h0: return 7'h20;
      3'h1: return 7'h10;
      3'h2, 3'h3: return 7'h08;
      3'h4: return 7'h04;
      3'h5: return 7'h02;
      default: return 7'h01;
    endcase
  endfunction
  function automatic logic pick(input int s);
    return s == 0 ? foe : ben[s-1];
  endfunction
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts edges until the picked output reaches v; a hang ends the run
  task automatic wait_on(input int s, input logic v, input int lim, output int n);
    for (n = 0; pick(s) !== v && n < lim; n++) @(posedge clk) #1;
    if (n == lim) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Every bus and handshake request starts on a clock edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic step_once();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (2) @(posedge clk);
    for (c = 0; busy === 1'b1 && c < 100; c++) @(posedge clk);
    if (c == 100) begin
      n_mismatch++;
      stop_test();
    end
    repeat (6) @(posedge clk);
    #1;
    e_idx = dir ? e_idx + inc : e_idx - inc;
    chk("index", 8'(idx), 8'(e_idx));
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, slp_n, imode} = 3'h7;
    {lsup, hot, raw_step, dir, lo, lohiz, hi, wr, rd, go} = '0;
    {ph, gate, dsel, dhiz, ochs, ocls, slow, addr, wdata} = '0;
    n_mismatch = 0;
    n_checks = 0;
    rs = 32'h0001_3b69;
    e_idx = 7'h10;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 chk("flag_pwrup", 8'(foe), 8'h01);
    wait_on(0, 1'b0, 100, c);
    chk("wake_len", 8'(c >= WAKE && c <= WAKE + 6), 8'h01);
    rd_reg(4'h0, d);
    chk("ready", d, 8'h10);
    wr_reg(4'h0, 8'h10);
    rd_reg(4'h0, d);
    chk("w1c", d, 8'h00);
    rd_reg(4'h2, d);
    chk("unmapped", d, 8'h00);
    for (k = 0; k < 12; k++) begin
      rs = xs(rs);
      {hi, lohiz, lo} <= mt[k % 6];
      inc = inc_of(mt[k % 6]);
      dir <= rs[0];
      slow <= rs[2:1];
      dhiz <= rs[4:3];
      repeat (4) @(posedge clk);
      #1 step_once();
      chk("idx_decay", 8'(dmode[1]), dhiz[1] ? 8'h02 : 8'h00);
    end
    slp_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("asleep", {reg_en, cp_en, clk_run, ben, foe}, 8'h01);
    chk("home", 8'(idx), 8'h10);
    chk("flag_pin", 8'(flag_n), 8'h00);
    for (k = 0; k < 6; k++) begin
      raw_step <= ~raw_step;
      dir <= rs[k];
      repeat (4) @(posedge clk);
    end
    #1 chk("sleep_idx", 8'(idx), 8'h10);
    e_idx = 7'h10;
    slp_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("wake_flag", 8'(foe), 8'h01);
    wait_on(0, 1'b0, 100, c);
    chk("wake_len2", 8'(c >= WAKE - 3 && c <= WAKE + 6), 8'h01);
    step_once();
    wr_reg(4'h4, 8'h01);
    ochs <= 2'h1;
    wait_on(1, 1'b0, 300, c);
    chk("oc_filter", 8'(c >= 150 && c <= 158), 8'h01);
    chk("oc_other", {ben, foe}, 8'h05);
    repeat (2) @(posedge clk);
    #1 chk("irq_on", 8'(irq), 8'h01);
    wait_on(1, 1'b1, RETRY + 10, c);
    chk("retry_len", 8'(c >= RETRY - 2 && c <= RETRY + 4), 8'h01);
    chk("retry_flag", 8'(foe), 8'h00);
    wait_on(1, 1'b0, 300, c);
    chk("retrip", 8'(c >= 150 && c <= 158), 8'h01);
    ochs <= 2'h0;
    wait_on(1, 1'b1, RETRY + 10, c);
    wr_reg(4'h0, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq_off", 8'(irq), 8'h00);
    ocls <= 2'h2;
    wait_on(2, 1'b0, 300, c);
    chk("oc_low_side", 8'(ben), 8'h01);
    ocls <= 2'h0;
    wait_on(2, 1'b1, RETRY + 10, c);
    hot <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("hot", {ben, foe}, 8'h01);
    hot <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("cool", {ben, foe}, 8'h06);
    step_once();
    lsup <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("low_sup", {idx, foe}, 8'h21);
    chk("low_sup_br", 8'(ben), 8'h00);
    lsup <= 1'b0;
    wait_on(0, 1'b0, 100, c);
    rd_reg(4'h0, d);
    chk("events", d, 8'h1e);
    rd_reg(4'h8, d);
    chk("state", d, 8'h04);
    rd_reg(4'hc, d);
    chk("index_reg", d, 8'h10);
    imode <= 1'b0;
    for (k = 0; k < 24; k++) begin
      rs = xs(rs);
      {hi, gate, ph, dsel, dhiz} <= rs[8:0];
      repeat (6) @(posedge clk);
      #1;
      for (b = 0; b < 2; b++) begin
        chk("coil_dir", 8'(cdir[b]), 8'(ph[b]));
        chk("drive_on", 8'(don[b]), 8'(gate[b]));
        chk("decay", 8'(dmode[b]), !gate[b] ? (hi ? 8'h03 : 8'h00) :
          (dhiz[b] ? 8'h02 : 8'(dsel[b])));
      end
    end
    stop_test();
  end
endmodule
